/* File: pkg/wdog_pkg.sv */
package wdog_pkg;
  // Source clock and tick rate
  localparam int unsigned SYS_CLK_HZ = 25000000;
  localparam int unsigned TICK_HZ = 256;
  localparam int unsigned TICK_DIV = SYS_CLK_HZ / TICK_HZ;
  // Watchdog counter width and overflow stage
  localparam int unsigned WDOG_WIDTH = 10;
  // Reset values
  localparam logic WDOG_ENABLE_RST = 1'b1;
  localparam logic [9:0] WDOG_COUNT_RST = 10'h000;
  // I/O address of the control bits
  localparam logic [15:0] WDOG_CTRL_ADDR = 16'hFF07;
  localparam int unsigned ENABLE_BIT_POS = 1;
  localparam int unsigned CLEAR_BIT_POS = 0;
  // Interrupt vector
  localparam logic [15:0] NMI_VECTOR = 16'h0100;
  // Overflow period in seconds
  localparam int unsigned OVERFLOW_MIN_S = 3;
  localparam int unsigned OVERFLOW_MAX_S = 4;
  typedef enum logic [1:0] {
    GATE_BLOCKED,
    GATE_HALF,
    GATE_OPEN
  } nmi_gate_type;
endpackage : wdog_pkg

/* File: logic/tick_divider.sv */
`timescale 1ns/100ps
module tick_divider #(
  parameter int unsigned DIV = wdog_pkg::TICK_DIV
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Restart and tick
  input wire logic restart,
  output logic tick
);
  logic [31:0] cnt_ff;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= 32'h00000000;
    end else if (restart || cnt_ff == DIV - 1) begin
      cnt_ff <= 32'h00000000;
    end else begin
      cnt_ff <= cnt_ff + 32'h00000001;
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tick <= 1'b0;
    end else begin
      tick <= !restart && (cnt_ff == DIV - 1);
    end
  end
endmodule : tick_divider

/* File: logic/watchdog_nmi_timer.sv */
`timescale 1ns/100ps
module watchdog_nmi_timer #(
  parameter int unsigned TICK_DIV = wdog_pkg::TICK_DIV,
  parameter int unsigned WIDTH = wdog_pkg::WDOG_WIDTH
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // I/O write and read port of the control bits
  input wire logic ioWrite,
  input wire logic [15:0] ioAddr,
  input wire logic [3:0] ioWrData,
  output logic [3:0] ioRdData,
  // CPU state
  input wire logic cpuHalted,
  input wire logic stack_pointer_first_half,
  input wire logic stack_pointer_second_half,
  input wire logic nmiTaken,
  // Interrupt outputs
  output logic nmiRequest,
  output logic nmiPending,
  output logic haltRelease,
  output logic [15:0] nmiVector,
  // Status
  output logic wdog_enable_bit,
  output logic [9:0] wdogCount
);
  logic ctrlSel;
  logic wdog_clear_strobe;
  logic tick;
  logic [WIDTH-1:0] cnt_ff;
  logic ovf;
  logic enable_ff;
  logic pend_ff;
  wdog_pkg::nmi_gate_type gate_ff;

  assign ctrlSel = ioWrite && (ioAddr == wdog_pkg::WDOG_CTRL_ADDR);
  assign wdog_clear_strobe = ctrlSel
    && ioWrData[wdog_pkg::CLEAR_BIT_POS];

  // Enable bit set by reset so the watchdog runs untouched
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      enable_ff <= wdog_pkg::WDOG_ENABLE_RST;
    end else if (ctrlSel) begin
      enable_ff <= ioWrData[wdog_pkg::ENABLE_BIT_POS];
    end
  end
  assign wdog_enable_bit = enable_ff;

  // Divider restarts on clear so the period is counted from the write
  tick_divider #(
    .DIV(TICK_DIV)
  ) u_tick (
    .sys_clk(sys_clk),
    .rst(rst),
    .restart(wdog_clear_strobe),
    .tick(tick)
  );

  // Overflow of the last stage: 1024 ticks at 256 Hz is 4 s
  assign ovf = tick && enable_ff && !wdog_clear_strobe
    && (&cnt_ff);

  // Halt does not gate the counter
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= WIDTH'(wdog_pkg::WDOG_COUNT_RST);
    end else if (wdog_clear_strobe) begin
      cnt_ff <= '0;
    end else if (tick && enable_ff) begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end
  assign wdogCount = 10'(cnt_ff);

  // Single cycle request per overflow
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      nmiRequest <= 1'b0;
    end else begin
      nmiRequest <= ovf;
    end
  end

  // Stack pointer pairing gate; after reset the interrupt is held off
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gate_ff <= wdog_pkg::GATE_BLOCKED;
    end else begin
      case (gate_ff)
        wdog_pkg::GATE_BLOCKED: begin
          if (stack_pointer_first_half) begin
            gate_ff <= wdog_pkg::GATE_HALF;
          end
        end
        wdog_pkg::GATE_HALF: begin
          if (stack_pointer_second_half) begin
            gate_ff <= wdog_pkg::GATE_OPEN;
          end
        end
        wdog_pkg::GATE_OPEN: begin
          if (stack_pointer_first_half) begin
            gate_ff <= wdog_pkg::GATE_HALF;
          end
        end
        default: begin
          gate_ff <= wdog_pkg::GATE_BLOCKED;
        end
      endcase
    end
  end

  // Pending latch: no interrupt disable flag input, so it cannot be masked.
  // New overflow wins over acceptance in the same cycle.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pend_ff <= 1'b0;
    end else if (ovf) begin
      pend_ff <= 1'b1;
    end else if (!enable_ff) begin
      pend_ff <= 1'b0;
    end else if (nmiTaken) begin
      pend_ff <= 1'b0;
    end
  end

  assign nmiPending = pend_ff
    && (gate_ff == wdog_pkg::GATE_OPEN);
  assign haltRelease = nmiPending && cpuHalted;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      nmiVector <= 16'h0000;
    end else begin
      nmiVector <= wdog_pkg::NMI_VECTOR;
    end
  end

  // Clear bit always reads 0
  always_comb begin
    ioRdData = 4'h0;
    if (ioAddr == wdog_pkg::WDOG_CTRL_ADDR) begin
      ioRdData[wdog_pkg::ENABLE_BIT_POS] = enable_ff;
    end
  end
endmodule : watchdog_nmi_timer

/* File: testbench/watchdog_nmi_timer_chk.sv */
`timescale 1ns/100ps
module watchdog_nmi_timer_chk (
  // Clock, reset and I/O port
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ioWrite,
  input wire logic [15:0] ioAddr,
  input wire logic [3:0] ioWrData,
  input wire logic [3:0] ioRdData,
  // Core side and status
  input wire logic cpuHalted,
  input wire logic nmiRequest,
  input wire logic nmiPending,
  input wire logic haltRelease,
  input wire logic [15:0] nmiVector,
  input wire logic wdog_enable_bit,
  input wire logic [9:0] wdogCount
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire wr = ioWrite && ioAddr == 16'hFF07;
  a_req_pulse: assert property (nmiRequest |=> !nmiRequest)
    else $error("long request");
  a_off_quiet: assert property (!wdog_enable_bit |=> !nmiRequest)
    else $error("request while off");
  a_halt_exit: assert property (
    haltRelease == (nmiPending && cpuHalted)) else $error("bad release");
  a_vec_set: assert property (
    !$past(rst) |-> nmiVector == 16'h0100) else $error("bad vector");
  a_clear_zero: assert property (
    wr && ioWrData[0] |=> wdogCount == 10'h000) else $error("no clear");
  a_enable_write: assert property (
    wr |=> wdog_enable_bit == $past(ioWrData[1])) else $error("bad enable");
  a_read_back: assert property (
    ioRdData == (ioAddr == 16'hFF07 ? {2'b00, wdog_enable_bit, 1'b0} : 4'h0))
    else $error("bad read");
  a_count_step: assert property ($changed(wdogCount) |->
    wdogCount == $past(wdogCount) + 10'h001 || wdogCount == 10'h000)
    else $error("bad count step");
  a_wrap_req: assert property (nmiRequest |-> wdogCount == 10'h000)
    else $error("request without wrap");
  cover property (nmiRequest);
  cover property (haltRelease);
  cover property (wr && ioWrData[0]);
endmodule : watchdog_nmi_timer_chk
bind watchdog_nmi_timer watchdog_nmi_timer_chk i_chk (.*);

/* File: testbench/cpu_nmi_model.sv */
`timescale 1ns/100ps
module cpu_nmi_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Bench controls and block outputs
  input wire logic haltCmd,
  input wire logic stall,
  input wire logic nmiPending,
  input wire logic haltRelease,
  // Core state
  output logic cpuHalted,
  output logic nmiTaken
);
  // Falling edge, so outputs settle well before the block samples them
  always_ff @(negedge sys_clk or posedge rst) begin
    if (rst) begin
      cpuHalted <= 1'b0;
      nmiTaken <= 1'b0;
    end else begin
      cpuHalted <= !haltRelease && (cpuHalted || haltCmd);
      // No disable flag looked at; stall stands for a slow core
      nmiTaken <= nmiPending && !nmiTaken && !stall;
    end
  end
endmodule : cpu_nmi_model

/* File: testbench/tb_top.sv */
`timescale 1ns/100ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
  n_errors++; $display("BAD %s exp %0h got %0h", n, e, g); end end
module tb_top;
  logic sys_clk = 0, rst = 1, ioWrite = 0, haltCmd = 1, stall = 1;
  logic stack_pointer_first_half = 0, stack_pointer_second_half = 0;
  logic [15:0] ioAddr = 16'hFF07;
  logic [3:0] ioWrData = 4'h0;
  logic [3:0] ioRdData;
  logic nmiRequest, nmiPending, haltRelease, cpuHalted, nmiTaken;
  logic wdog_enable_bit;
  logic [15:0] nmiVector;
  logic [9:0] wdogCount, hold;
  int n_errors = 0, tests_run = 0, cyc = 0, reqs = 0, c = 0;
  // Small divider keeps a full overflow near 4096 cycles
  watchdog_nmi_timer #(.TICK_DIV(4)) i_watchdog_nmi_timer (.*);
  cpu_nmi_model i_cpu_nmi_model (.*);
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (nmiRequest === 1'b1) reqs++;
    if (cyc == 60000) begin
      n_errors++;
      summarize();
    end
  end
  task automatic wr(input logic [15:0] a, input logic [3:0] d);
    @(negedge sys_clk);
    ioAddr = a;
    ioWrData = d;
    ioWrite = 1;
    @(negedge sys_clk);
    ioWrite = 0;
    ioAddr = 16'hFF07;
  endtask : wr
  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : idle
  task automatic summarize();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  initial begin
    c = $urandom(32'he753);
    idle(3);
    rst = 0;
    `CHK("enable", 1'b1, wdog_enable_bit)
    idle(2);
    haltCmd = 0;
    for (c = 0; reqs == 0 && c < 4200; c++) idle(1);
    `CHK("ovf time", 1'b1, c > 4090 && c < 4100)
    `CHK("gated", 1'b0, nmiPending)
    idle(1);
    stack_pointer_first_half = 1;
    idle(1);
    stack_pointer_first_half = 0;
    stack_pointer_second_half = 1;
    idle(1);
    stack_pointer_second_half = 0;
    `CHK("pend", 1'b1, nmiPending)
    stall = 0;
    idle(3);
    `CHK("taken", 1'b0, nmiPending)
    `CHK("woken", 1'b0, cpuHalted)
    $display("end halt and gate");
    reqs = 0;
    repeat (6) begin
      idle(100 + $urandom % 3900);
      wr(16'hFF07, 4'h3);
      `CHK("cleared", 1'b1, wdogCount < 10'h2)
      wr(16'hFF00 + 16'($urandom % 7), 4'($urandom));
      `CHK("other addr", 1'b1, wdog_enable_bit)
    end
    `CHK("no nmi", 0, reqs)
    idle(40);
    wr(16'hFF07, 4'h2);
    `CHK("no clear", 1'b1, wdogCount > 10'h8)
    wr(16'hFF07, 4'h0);
    hold = wdogCount;
    idle(5000);
    `CHK("off", 1'b0, wdog_enable_bit)
    `CHK("frozen", hold, wdogCount)
    `CHK("quiet", 0, reqs)
    $display("end clear and stop");
    wr(16'hFF07, 4'h3);
    idle(4200);
    `CHK("one pulse", 1, reqs)
    `CHK("wrapped", 1'b1, wdogCount < 10'h40)
    $display("end wrap");
    summarize();
  end
endmodule : tb_top
